// ---- rtl/cap_wake_pkg.sv ----
package cap_wake_pkg;

  // ==========================================================
  // Register indices (printed offsets are not multiples of four)
  localparam logic [3:0]  IDX_CH1_WAKE_CONTROL   = 4'h4;
  localparam logic [3:0]  IDX_CH2_WAKE_CONTROL   = 4'h5;
  localparam logic [3:0]  IDX_EXC_LOW_LIMIT      = 4'h6;
  localparam logic [3:0]  IDX_EXC_SPREAD_BW      = 4'h7;
  localparam logic [3:0]  IDX_CH1_RESULT_LOW     = 4'h8;
  localparam logic [3:0]  IDX_STANDBY_CONTROL    = 4'h3;
  localparam logic [3:0]  IDX_IRQ_STATUS         = 4'h9;
  localparam logic [3:0]  IDX_IRQ_ENABLE         = 4'hA;
  localparam logic [3:0]  IDX_IRQ_CLEAR          = 4'hB;

  // ==========================================================
  // Field positions and masks
  localparam int          BIT_ABS_EN             = 0;
  localparam int          BIT_SLOPE_EN           = 1;
  localparam int          BIT_COMBINE            = 2;
  localparam int          BIT_OVERRANGE          = 0;
  localparam int          BIT_STANDBY            = 0;
  localparam int          BIT_IRQ_WAKE1          = 0;
  localparam int          BIT_IRQ_WAKE2          = 1;
  localparam int          BIT_IRQ_CONV1          = 2;
  localparam logic [7:0]  MASK_WAKE_CONTROL      = 8'h07;
  localparam logic [7:0]  MASK_EXC_LOW_LIMIT     = 8'h3F;
  localparam logic [7:0]  MASK_EXC_SPREAD_BW     = 8'h1F;
  localparam logic [7:0]  MASK_CH1_RESULT_LOW    = 8'hF1;
  localparam logic [7:0]  MASK_IRQ               = 8'h07;

  // ==========================================================
  // Reset values
  localparam logic [7:0]  RST_CH1_WAKE_CONTROL   = 8'h00;
  localparam logic [7:0]  RST_CH2_WAKE_CONTROL   = 8'h04;
  localparam logic [7:0]  RST_EXC_LOW_LIMIT      = 8'h1E;
  localparam logic [7:0]  RST_EXC_SPREAD_BW      = 8'h00;
  localparam logic [7:0]  RST_CH1_RESULT_LOW     = 8'h00;

  // ==========================================================
  // Frequency steps in kHz
  localparam int          LOW_LIMIT_STEP_KHZ     = 10;
  localparam int          SPREAD_STEP_KHZ        = 20;

endpackage : cap_wake_pkg

// ---- rtl/cap_wake_regs.sv ----
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - Ch1 slope enable gates ch1 slope detection
// - Ch1 combine: AND both, else OR
// - Ch2 absolute enable gates ch2 absolute detection
// - Ch2 slope enable gates ch2 slope detection
// - Ch2 combine: AND both, else OR
// - Ch2 wake control resets to 04h
// - Six-bit low limit, 10 kHz steps
// - Low limit register resets to 1Eh
// - Five-bit spread bandwidth, 20 kHz steps
// - Ch1 low result is read-only
// - Overrange flag follows each ch1 conversion
// - Ch1 absolute enable gates ch1 absolute detection
// - Wake event clears standby enable
module cap_wake_regs (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_b,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [31:0] i_paddr,
  input  wire logic [31:0] i_pwdata,
  input  wire logic [3:0]  i_pstrb,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_ch1_abs_exceeded,
  input  wire logic        i_ch1_slope_exceeded,
  input  wire logic        i_ch2_abs_exceeded,
  input  wire logic        i_ch2_slope_exceeded,
  input  wire logic        i_ch1_conv_done,
  input  wire logic        i_ch1_conv_overrange,
  input  wire logic [3:0]  i_ch1_result_low_bits,
  output logic             o_ch1_absolute_detect_en,
  output logic             o_ch1_slope_detect_en,
  output logic             o_ch2_absolute_detect_en,
  output logic             o_ch2_slope_detect_en,
  output logic             o_standby_enable,
  output logic      [5:0]  o_excitation_low_limit,
  output logic      [4:0]  o_excitation_spread_bandwidth,
  output logic      [15:0] o_low_limit_khz,
  output logic      [15:0] o_spread_khz,
  output logic             o_wake_event,
  output logic             o_irq
);

  // ==========================================================
  // Bus decode
  logic       acc;
  logic       wr;
  logic       addr_ok;
  logic [3:0] idx;
  logic [7:0] wbyte;

  assign idx     = i_paddr[5:2];
  assign addr_ok = (i_paddr[31:6] == 26'h0) && (i_paddr[1:0] == 2'h0) &&
                   (idx == cap_wake_pkg::IDX_CH1_WAKE_CONTROL ||
                    idx == cap_wake_pkg::IDX_CH2_WAKE_CONTROL ||
                    idx == cap_wake_pkg::IDX_EXC_LOW_LIMIT ||
                    idx == cap_wake_pkg::IDX_EXC_SPREAD_BW ||
                    idx == cap_wake_pkg::IDX_CH1_RESULT_LOW ||
                    idx == cap_wake_pkg::IDX_STANDBY_CONTROL ||
                    idx == cap_wake_pkg::IDX_IRQ_STATUS ||
                    idx == cap_wake_pkg::IDX_IRQ_ENABLE ||
                    idx == cap_wake_pkg::IDX_IRQ_CLEAR);
  assign acc     = i_psel && i_penable;
  assign wr      = acc && i_pwrite && addr_ok && i_pstrb[0];
  assign wbyte   = i_pwdata[7:0];
  assign o_pready  = 1'b1;
  assign o_pslverr = acc && !addr_ok;

  // ==========================================================
  // Register state
  logic [7:0]  ch1_wake_control_q;
  logic [7:0]  ch1_wake_control_d;
  logic [7:0]  ch2_wake_control_q;
  logic [7:0]  ch2_wake_control_d;
  logic [7:0]  low_limit_q;
  logic [7:0]  low_limit_d;
  logic [7:0]  spread_bw_q;
  logic [7:0]  spread_bw_d;
  logic [7:0]  result_low_q;
  logic [7:0]  result_low_d;
  logic        standby_q;
  logic        standby_d;
  logic [7:0]  irq_status_q;
  logic [7:0]  irq_status_d;
  logic [7:0]  irq_enable_q;
  logic [7:0]  irq_enable_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // ==========================================================
  // Detection and event signals
  logic        abs1;
  logic        slope1;
  logic        abs2;
  logic        slope2;
  logic        wake1;
  logic        wake2;
  logic        wake;
  logic [7:0]  ev;
  logic [7:0]  clr;

  // ==========================================================
  // Per-register write strobes
  logic        wr_ch1_wake;
  logic        wr_ch2_wake;
  logic        wr_low_limit;
  logic        wr_spread_bw;
  logic        wr_standby;
  logic        wr_irq_enable;
  logic        wr_irq_clear;

  assign wr_ch1_wake   = wr && (idx == cap_wake_pkg::IDX_CH1_WAKE_CONTROL);
  assign wr_ch2_wake   = wr && (idx == cap_wake_pkg::IDX_CH2_WAKE_CONTROL);
  assign wr_low_limit  = wr && (idx == cap_wake_pkg::IDX_EXC_LOW_LIMIT);
  assign wr_spread_bw  = wr && (idx == cap_wake_pkg::IDX_EXC_SPREAD_BW);
  assign wr_standby    = wr && (idx == cap_wake_pkg::IDX_STANDBY_CONTROL);
  assign wr_irq_enable = wr && (idx == cap_wake_pkg::IDX_IRQ_ENABLE);
  assign wr_irq_clear  = wr && (idx == cap_wake_pkg::IDX_IRQ_CLEAR);

  // ==========================================================
  // Detection gating per channel
  assign abs1   = ch1_wake_control_q[cap_wake_pkg::BIT_ABS_EN] &&
                  i_ch1_abs_exceeded;
  assign slope1 = ch1_wake_control_q[cap_wake_pkg::BIT_SLOPE_EN] &&
                  i_ch1_slope_exceeded;
  assign abs2   = ch2_wake_control_q[cap_wake_pkg::BIT_ABS_EN] &&
                  i_ch2_abs_exceeded;
  assign slope2 = ch2_wake_control_q[cap_wake_pkg::BIT_SLOPE_EN] &&
                  i_ch2_slope_exceeded;

  // AND/OR combine; AND with a cleared enable never fires
  always_comb begin
    if (ch1_wake_control_q[cap_wake_pkg::BIT_COMBINE]) begin
      wake1 = abs1 && slope1;
    end else begin
      wake1 = abs1 || slope1;
    end
    if (ch2_wake_control_q[cap_wake_pkg::BIT_COMBINE]) begin
      wake2 = abs2 && slope2;
    end else begin
      wake2 = abs2 || slope2;
    end
    wake = standby_q && (wake1 || wake2);
  end

  // Wake events only count while standby is armed; the conversion event always counts
  always_comb begin
    ev = 8'h00;
    ev[cap_wake_pkg::BIT_IRQ_WAKE1] = standby_q && wake1;
    ev[cap_wake_pkg::BIT_IRQ_WAKE2] = standby_q && wake2;
    ev[cap_wake_pkg::BIT_IRQ_CONV1] = i_ch1_conv_done;
    if (wr_irq_clear) begin
      clr = wbyte;
    end else begin
      clr = 8'h00;
    end
  end

  // ==========================================================
  // Wake control registers
  always_comb begin
    ch1_wake_control_d = ch1_wake_control_q;
    ch2_wake_control_d = ch2_wake_control_q;
    if (wr_ch1_wake) begin
      ch1_wake_control_d = wbyte & cap_wake_pkg::MASK_WAKE_CONTROL;
    end
    if (wr_ch2_wake) begin
      ch2_wake_control_d = wbyte & cap_wake_pkg::MASK_WAKE_CONTROL;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      ch1_wake_control_q <= cap_wake_pkg::RST_CH1_WAKE_CONTROL;
      ch2_wake_control_q <= cap_wake_pkg::RST_CH2_WAKE_CONTROL;
    end else begin
      ch1_wake_control_q <= ch1_wake_control_d;
      ch2_wake_control_q <= ch2_wake_control_d;
    end
  end

  // ==========================================================
  // Excitation frequency registers
  always_comb begin
    low_limit_d = low_limit_q;
    spread_bw_d = spread_bw_q;
    if (wr_low_limit) begin
      low_limit_d = wbyte & cap_wake_pkg::MASK_EXC_LOW_LIMIT;
    end
    if (wr_spread_bw) begin
      spread_bw_d = wbyte & cap_wake_pkg::MASK_EXC_SPREAD_BW;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      low_limit_q <= cap_wake_pkg::RST_EXC_LOW_LIMIT;
      spread_bw_q <= cap_wake_pkg::RST_EXC_SPREAD_BW;
    end else begin
      low_limit_q <= low_limit_d;
      spread_bw_q <= spread_bw_d;
    end
  end

  // ==========================================================
  // Channel 1 low result, loaded by hardware only
  always_comb begin
    result_low_d = result_low_q;
    if (i_ch1_conv_done) begin
      result_low_d = {i_ch1_result_low_bits, 3'b000, i_ch1_conv_overrange};
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      result_low_q <= cap_wake_pkg::RST_CH1_RESULT_LOW;
    end else begin
      result_low_q <= result_low_d;
    end
  end

  // ==========================================================
  // Standby enable; a wake event beats a software write
  always_comb begin
    standby_d = standby_q;
    if (wr_standby) begin
      standby_d = wbyte[cap_wake_pkg::BIT_STANDBY];
    end
    if (wake) begin
      standby_d = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      standby_q <= 1'b0;
    end else begin
      standby_q <= standby_d;
    end
  end

  // ==========================================================
  // Interrupt status and enable
  always_comb begin
    irq_enable_d = irq_enable_q;
    // Set wins over clear
    irq_status_d = ((irq_status_q & ~clr) | ev) & cap_wake_pkg::MASK_IRQ;
    if (wr_irq_enable) begin
      irq_enable_d = wbyte & cap_wake_pkg::MASK_IRQ;
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      irq_status_q <= 8'h00;
      irq_enable_q <= 8'h00;
    end else begin
      irq_status_q <= irq_status_d;
      irq_enable_q <= irq_enable_d;
    end
  end

  // ==========================================================
  // Read data registered at setup, presented in access phase
  always_comb begin
    rdata_d = rdata_q;
    if (i_psel && !i_penable) begin
      rdata_d = 32'h0000_0000;
      unique case (idx)
        cap_wake_pkg::IDX_CH1_WAKE_CONTROL: rdata_d[7:0] = ch1_wake_control_q;
        cap_wake_pkg::IDX_CH2_WAKE_CONTROL: rdata_d[7:0] = ch2_wake_control_q;
        cap_wake_pkg::IDX_EXC_LOW_LIMIT:    rdata_d[7:0] = low_limit_q;
        cap_wake_pkg::IDX_EXC_SPREAD_BW:    rdata_d[7:0] = spread_bw_q;
        cap_wake_pkg::IDX_CH1_RESULT_LOW:
          rdata_d[7:0] = result_low_q & cap_wake_pkg::MASK_CH1_RESULT_LOW;
        cap_wake_pkg::IDX_STANDBY_CONTROL:  rdata_d[0]   = standby_q;
        cap_wake_pkg::IDX_IRQ_STATUS:       rdata_d[7:0] = irq_status_q;
        cap_wake_pkg::IDX_IRQ_ENABLE:       rdata_d[7:0] = irq_enable_q;
        default: ;
      endcase
      if (!addr_ok) begin
        rdata_d = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_b) begin
      rdata_q <= 32'h0000_0000;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Outputs
  assign o_prdata                      = rdata_q;
  assign o_ch1_absolute_detect_en      = ch1_wake_control_q[cap_wake_pkg::BIT_ABS_EN];
  assign o_ch1_slope_detect_en         = ch1_wake_control_q[cap_wake_pkg::BIT_SLOPE_EN];
  assign o_ch2_absolute_detect_en      = ch2_wake_control_q[cap_wake_pkg::BIT_ABS_EN];
  assign o_ch2_slope_detect_en         = ch2_wake_control_q[cap_wake_pkg::BIT_SLOPE_EN];
  assign o_standby_enable              = standby_q;
  assign o_excitation_low_limit        = low_limit_q[5:0];
  assign o_excitation_spread_bandwidth = spread_bw_q[4:0];
  assign o_low_limit_khz = 16'(low_limit_q[5:0]) *
                           16'(cap_wake_pkg::LOW_LIMIT_STEP_KHZ);
  assign o_spread_khz    = 16'(spread_bw_q[4:0]) *
                           16'(cap_wake_pkg::SPREAD_STEP_KHZ);
  assign o_wake_event    = wake;
  assign o_irq           = |(irq_status_q & irq_enable_q);

endmodule : cap_wake_regs

`default_nettype wire

// ---- tb/cap_wake_regs_monitor.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========================
// Port-level checks
module cap_wake_regs_monitor (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_b,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [31:0] i_paddr,
  input wire logic        i_ch1_abs_exceeded,
  input wire logic        i_ch1_slope_exceeded,
  input wire logic        i_ch2_abs_exceeded,
  input wire logic        i_ch2_slope_exceeded,
  input wire logic        i_ch1_conv_done,
  input wire logic        i_ch1_conv_overrange,
  input wire logic [31:0] o_prdata,
  input wire logic        o_pslverr,
  input wire logic        o_ch1_absolute_detect_en,
  input wire logic        o_ch1_slope_detect_en,
  input wire logic        o_ch2_absolute_detect_en,
  input wire logic        o_ch2_slope_detect_en,
  input wire logic        o_standby_enable,
  input wire logic [5:0]  o_excitation_low_limit,
  input wire logic [4:0]  o_excitation_spread_bandwidth,
  input wire logic [15:0] o_low_limit_khz,
  input wire logic [15:0] o_spread_khz,
  input wire logic        o_wake_event
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  logic rd;
  assign rd = i_psel && i_penable && !i_pwrite;
  property p_rst; $rose(i_rst_b) |-> o_excitation_low_limit == 6'h1E
    && !o_ch2_absolute_detect_en && !o_ch2_slope_detect_en; endproperty
  a_rst: assert property (p_rst) else $error("bad reset value");
  property p_khz; o_low_limit_khz == 16'(o_excitation_low_limit) * 16'h000A
    && o_spread_khz == 16'(o_excitation_spread_bandwidth) * 16'h0014; endproperty
  a_khz: assert property (p_khz) else $error("bad kHz scaling");
  property p_hold; !(i_psel && i_penable && i_pwrite) |=> $stable(o_excitation_low_limit)
    && $stable(o_excitation_spread_bandwidth); endproperty
  a_hold: assert property (p_hold) else $error("field moved");
  property p_gate; o_wake_event |-> o_standby_enable
    && (i_ch1_abs_exceeded && o_ch1_absolute_detect_en
    || i_ch1_slope_exceeded && o_ch1_slope_detect_en
    || i_ch2_abs_exceeded && o_ch2_absolute_detect_en
    || i_ch2_slope_exceeded && o_ch2_slope_detect_en); endproperty
  a_gate: assert property (p_gate) else $error("ungated wake");
  property p_wclr; o_wake_event |=> !o_standby_enable; endproperty
  a_wclr: assert property (p_wclr) else $error("standby kept");
  property p_ro; rd && i_paddr == 32'h00000020 |-> o_prdata[3:1] == 3'h0
    && o_prdata[31:8] == 24'h000000; endproperty
  a_ro: assert property (p_ro) else $error("reserved bits set");
  property p_ovr; i_ch1_conv_done ##2 (rd && i_paddr == 32'h00000020)
    |-> o_prdata[0] == $past(i_ch1_conv_overrange, 2); endproperty
  a_ovr: assert property (p_ovr) else $error("overrange flag");
  property p_err; rd && i_paddr == 32'h00000040 |-> o_pslverr
    && o_prdata == 32'h00000000; endproperty
  a_err: assert property (p_err) else $error("unmapped read");
endmodule : cap_wake_regs_monitor
`default_nettype wire

// ---- tb/cap_wake_regs_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module cap_wake_regs_tb;
  logic i_sys_clk, i_rst_b, i_psel, i_penable, i_pwrite, i_ch1_conv_done, i_ch1_conv_overrange;
  logic i_ch1_abs_exceeded, i_ch1_slope_exceeded, i_ch2_abs_exceeded, i_ch2_slope_exceeded;
  logic o_ch1_absolute_detect_en, o_ch1_slope_detect_en, o_ch2_absolute_detect_en;
  logic o_ch2_slope_detect_en, o_standby_enable, o_wake_event, o_pready, o_pslverr, o_irq;
  logic [31:0] i_paddr, i_pwdata, o_prdata;
  logic [3:0]  i_pstrb, i_ch1_result_low_bits, exc;
  logic [5:0]  o_excitation_low_limit;
  logic [4:0]  o_excitation_spread_bandwidth;
  logic [15:0] o_low_limit_khz, o_spread_khz;
  logic [31:0] exp_q[$];
  logic [7:0]  v;
  logic [7:0]  tc[11];
  int          n_errors, checks_done, cyc;
  assign {i_ch1_abs_exceeded, i_ch1_slope_exceeded} = exc[3:2];
  assign {i_ch2_abs_exceeded, i_ch2_slope_exceeded} = exc[1:0];
  cap_wake_regs u_dut (
    .i_sys_clk                     (i_sys_clk),
    .i_rst_b                       (i_rst_b),
    .i_psel                        (i_psel),
    .i_penable                     (i_penable),
    .i_pwrite                      (i_pwrite),
    .i_paddr                       (i_paddr),
    .i_pwdata                      (i_pwdata),
    .i_pstrb                       (i_pstrb),
    .o_prdata                      (o_prdata),
    .o_pready                      (o_pready),
    .o_pslverr                     (o_pslverr),
    .i_ch1_abs_exceeded            (i_ch1_abs_exceeded),
    .i_ch1_slope_exceeded          (i_ch1_slope_exceeded),
    .i_ch2_abs_exceeded            (i_ch2_abs_exceeded),
    .i_ch2_slope_exceeded          (i_ch2_slope_exceeded),
    .i_ch1_conv_done               (i_ch1_conv_done),
    .i_ch1_conv_overrange          (i_ch1_conv_overrange),
    .i_ch1_result_low_bits         (i_ch1_result_low_bits),
    .o_ch1_absolute_detect_en      (o_ch1_absolute_detect_en),
    .o_ch1_slope_detect_en         (o_ch1_slope_detect_en),
    .o_ch2_absolute_detect_en      (o_ch2_absolute_detect_en),
    .o_ch2_slope_detect_en         (o_ch2_slope_detect_en),
    .o_standby_enable              (o_standby_enable),
    .o_excitation_low_limit        (o_excitation_low_limit),
    .o_excitation_spread_bandwidth (o_excitation_spread_bandwidth),
    .o_low_limit_khz               (o_low_limit_khz),
    .o_spread_khz                  (o_spread_khz),
    .o_wake_event                  (o_wake_event),
    .o_irq                         (o_irq)
  );
  always #5 i_sys_clk = ~i_sys_clk;
  // ==========================
  // Bus and scenario tasks
  task automatic report_and_stop;
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge i_sys_clk);
    i_psel <= 1'b1;
    i_pwrite <= w;
    i_paddr <= {24'h000000, a};
    i_pwdata <= {24'h000000, d};
    i_ch1_conv_done <= 1'b0;
    @(posedge i_sys_clk);
    i_penable <= 1'b1;
    @(posedge i_sys_clk);
    while (o_pready !== 1'b1)
      @(posedge i_sys_clk);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back({24'h000000, e});
    apb(1'b0, a, 8'h00);
  endtask : rd
  // Table byte: ch, wake expected, abs, slope, -, control
  task automatic wake(input logic [7:0] t);
    apb(1'b1, 8'h2C, 8'h07);
    apb(1'b1, t[7] ? 8'h14 : 8'h10, {5'h00, t[2:0]});
    apb(1'b1, 8'h0C, 8'h01);
    @(posedge i_sys_clk);
    exc <= t[7] ? {2'b00, t[5:4]} : {t[5:4], 2'b00};
    repeat (2) @(posedge i_sys_clk);
    exc <= 4'h0;
    rd(8'h0C, {7'h00, !t[6]});
    rd(8'h24, {6'h00, t[6] & t[7], t[6] & !t[7]});
    checks_done++;
    if (o_irq !== t[6]) begin
      n_errors++;
      $display("ERROR %0t interrupt level mismatch", $time);
    end
  endtask : wake
  // ==========================
  // Result checker and watchdog
  always @(posedge i_sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      report_and_stop();
    end
    if (i_psel && i_penable && !i_pwrite && o_pready === 1'b1) begin
      checks_done++;
      if (exp_q.size() == 0 || o_prdata !== exp_q.pop_front()) begin
        n_errors++;
        $display("ERROR %0t read data mismatch", $time);
      end
    end
  end
  initial begin
    {i_sys_clk, i_rst_b, i_psel, i_penable, i_pwrite} = 5'h00;
    {i_ch1_conv_done, i_ch1_conv_overrange, exc, i_ch1_result_low_bits} = 10'h000;
    i_paddr = 32'h00000000;
    i_pwdata = 32'h00000000;
    i_pstrb = 4'hF;
    n_errors = 0;
    checks_done = 0;
    cyc = 0;
    tc = '{8'h27, 8'h77, 8'h53, 8'h22, 8'h61, 8'hA7, 8'h97, 8'hF7, 8'hE1, 8'hD2, 8'h91};
    v = 8'($urandom(32'h73DD5C6C));
    repeat (20) @(posedge i_sys_clk);
    i_rst_b <= 1'b1;
    rd(8'h14, 8'h04);
    rd(8'h18, 8'h1E);
    rd(8'h1C, 8'h00);
    rd(8'h20, 8'h00);
    rd(8'h40, 8'h00);
    for (int i = 0; i < 4; i++) begin
      v = 8'($urandom());
      apb(1'b1, 8'h18, v);
      rd(8'h18, v & 8'h3F);
      apb(1'b1, 8'h1C, v);
      rd(8'h1C, v & 8'h1F);
      apb(1'b1, 8'h14, v);
      rd(8'h14, v & 8'h07);
      apb(1'b1, 8'h20, v);
      rd(8'h20, 8'h00);
    end
    for (int i = 0; i < 2; i++) begin
      v = 8'($urandom());
      @(posedge i_sys_clk);
      i_ch1_conv_done <= 1'b1;
      i_ch1_conv_overrange <= ~i[0];
      i_ch1_result_low_bits <= v[3:0];
      rd(8'h20, {v[3:0], 3'h0, ~i[0]});
    end
    apb(1'b1, 8'h28, 8'h07);
    rd(8'h28, 8'h07);
    foreach (tc[i]) wake(tc[i]);
    apb(1'b1, 8'h28, 8'h00);
    report_and_stop();
  end
endmodule : cap_wake_regs_tb
bind cap_wake_regs cap_wake_regs_monitor u_mon (.*);
`default_nettype wire
